// File: halfbridge_fault_status_word.sv
// serial status word for half-bridges 6 to 1 with its serial link end
`timescale 1ns/1ps
// Overview of operation
// - every status bit and latched flag clears to zero at power-on reset.
// - bit 14 reports a supply fault when either driver supply is out of range.
// - supply fault clears when supply returns inside the undervoltage/overvoltage limits.
// - thermal shutdown flag latches, leads the word, clears on reset request when cool.
// - field codes: 00 disabled, 01 overcurrent, 10 underload.
// - each 2-bit field is priority encoded, one state per half-bridge.
// - half-bridge 6 state sits at bits 12 and 11.
// - half-bridge 5 state sits at bits 10 and 9.
// - half-bridge 4 state sits at bits 8 and 7.
// - half-bridge 3 at bits 6 and 5, lower channels below in order.
// - field reads 11 when output enabled and fault free.
// - this layout is returned when previous command group-select bit was 0.
// - underload may move to overcurrent; overcurrent holds until cleared.
module halfbridge_fault_status_word
    import status_word_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic serial_clock_in,
    input wire logic chip_select_n_in,
    input wire logic serial_data_in,
    input wire logic [CHANNELS-1:0] channel_enable_in,
    input wire logic [CHANNELS-1:0] overcurrent_in,
    input wire logic [CHANNELS-1:0] underload_in,
    input wire logic thermal_shutdown_in,
    input wire logic thermal_warning_in,
    input wire logic undervoltage_in,
    input wire logic overvoltage_in,
    output logic serial_data_out,
    output logic serial_data_oe_n_out,
    output logic thermal_shutdown_latched_out,
    output logic [WORD_BITS-1:0] serial_status_word_out,
    output logic channel_group_select_out
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int PIN_BITS = 3 * CHANNELS + 4;
    logic [PIN_BITS-1:0] pins_meta_reg;
    logic [PIN_BITS-1:0] pins_reg;
    logic [CHANNELS-1:0] enable_s;
    logic [CHANNELS-1:0] overcurrent_s;
    logic [CHANNELS-1:0] underload_s;
    logic thermal_shutdown_s;
    logic thermal_warning_s;
    logic undervoltage_s;
    logic overvoltage_s;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            pins_meta_reg <= '0;
            pins_reg <= '0;
        end else begin
            pins_meta_reg <= {channel_enable_in, overcurrent_in, underload_in,
                thermal_shutdown_in, thermal_warning_in, undervoltage_in, overvoltage_in};
            pins_reg <= pins_meta_reg;
        end
    end

    assign {enable_s, overcurrent_s, underload_s, thermal_shutdown_s,
        thermal_warning_s, undervoltage_s, overvoltage_s} = pins_reg;

    // ************************************************************
    // link domain: shifting on the master's clock
    // ************************************************************
    // chip select high ends the frame, so it clears the link state
    // without needing any further serial clock edges
    logic [COUNT_BITS-1:0] bit_count_reg;
    logic [WORD_BITS-1:0] tx_shift_reg;
    logic [WORD_BITS-1:0] rx_shift_reg;
    logic tx_bit_reg;
    logic started_reg;
    logic [WORD_BITS-1:0] hold_reg;
    wire first_edge = (bit_count_reg == COUNT_RESET);
    wire [COUNT_BITS-1:0] count_step = bit_count_reg + 5'h01;

    always_ff @(posedge serial_clock_in or posedge chip_select_n_in) begin
        if (chip_select_n_in) begin
            bit_count_reg <= COUNT_RESET;
            tx_shift_reg <= STATUS_RESET;
            tx_bit_reg <= 1'b0;
            started_reg <= 1'b0;
        end else begin
            started_reg <= 1'b1;
            if (bit_count_reg != COUNT_LAST) begin
                bit_count_reg <= count_step;
            end
            if (first_edge) begin
                tx_bit_reg <= hold_reg[WORD_BITS-1];
                tx_shift_reg <= {hold_reg[WORD_BITS-2:0], serial_data_in};
            end else begin
                tx_bit_reg <= tx_shift_reg[WORD_BITS-1];
                tx_shift_reg <= {tx_shift_reg[WORD_BITS-2:0], serial_data_in};
            end
        end
    end

    // command bits stay still while chip select is high, so the
    // core domain reads them after it sees the frame end
    always_ff @(posedge serial_clock_in) begin
        rx_shift_reg <= {rx_shift_reg[WORD_BITS-2:0], serial_data_in};
    end

    // ************************************************************
    // crossings into the core domain
    // ************************************************************
    logic [2:0] link_meta_reg;
    logic [2:0] link_reg;
    logic cs_prev_reg;
    wire cs_high_s = link_reg[2];
    wire started_s = link_reg[1];
    wire tx_bit_s = link_reg[0];
    wire frame_end = cs_high_s & ~cs_prev_reg;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            link_meta_reg <= 3'h4;
            link_reg <= 3'h4;
            cs_prev_reg <= 1'b1;
        end else begin
            link_meta_reg <= {chip_select_n_in, started_reg, tx_bit_reg};
            link_reg <= link_meta_reg;
            cs_prev_reg <= cs_high_s;
        end
    end

    // ************************************************************
    // command capture and latched flags
    // ************************************************************
    logic [WORD_BITS-1:0] cmd_reg;
    logic tsd_reg;
    logic tsd_next;
    wire reset_request = frame_end & rx_shift_reg[CMD_RESET_BIT];

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cmd_reg <= CMD_RESET;
        end else if (frame_end) begin
            cmd_reg <= rx_shift_reg;
        end
    end

    // clears only on request once cool; new shutdown wins
    assign tsd_next = thermal_shutdown_s | (tsd_reg & ~(reset_request & ~thermal_shutdown_s));

    logic [CHANNELS-1:0] ocs_latched;
    logic [FIELD_BITS*CHANNELS-1:0] fields;

    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++) begin : g_channel
            half_bridge_state_encoder encoder (
                .clock_in(clock_in),
                .rst_n_in(rst_n_in),
                .enable_in(enable_s[ch]),
                .overcurrent_in(overcurrent_s[ch]),
                .underload_in(underload_s[ch]),
                .clear_in(reset_request),
                .overcurrent_shutdown_latched_out(ocs_latched[ch]),
                .half_bridge_state_field_out(fields[FIELD_BITS*ch +: FIELD_BITS])
            );
        end
    endgenerate

    // ************************************************************
    // status word assembly
    // ************************************************************
    // either supply out of range
    // flag follows the supply back into range
    wire supply_fault_flag = undervoltage_s | overvoltage_s;
    wire underload_flag = |underload_s;
    wire channel_group_select = cmd_reg[CMD_GROUP_BIT];
    logic [WORD_BITS-1:0] word;

    // fields only for group 0; other group not built here
    assign word[OVERCURRENT_BIT] = |ocs_latched;
    assign word[SUPPLY_FAULT_BIT] = supply_fault_flag;
    assign word[UNDERLOAD_BIT] = underload_flag;
    assign word[FIELD_BASE_BIT +: FIELD_BITS*CHANNELS] =
        channel_group_select ? '0 : fields;
    assign word[THERMAL_WARNING_BIT] = thermal_warning_s;

    // ************************************************************
    // output registers
    // ************************************************************
    logic [WORD_BITS-1:0] hold_next;
    logic so_next;
    // word frozen while a frame runs
    assign hold_next = cs_high_s ? word : hold_reg;
    // flag leads the word until the first serial edge
    assign so_next = started_s ? tx_bit_s : tsd_reg;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            tsd_reg <= 1'b0;
            hold_reg <= STATUS_RESET;
            serial_data_out <= 1'b0;
            serial_data_oe_n_out <= 1'b1;
            thermal_shutdown_latched_out <= 1'b0;
            serial_status_word_out <= STATUS_RESET;
            channel_group_select_out <= 1'b0;
        end else begin
            tsd_reg <= tsd_next;
            hold_reg <= hold_next;
            serial_data_out <= so_next;
            serial_data_oe_n_out <= cs_high_s;
            thermal_shutdown_latched_out <= tsd_reg;
            serial_status_word_out <= word;
            channel_group_select_out <= channel_group_select;
        end
    end
endmodule

// File: status_word_pkg.sv
// shared constants for the half-bridge serial status word
package status_word_pkg;
    localparam int CHANNELS = 6;
    localparam int WORD_BITS = 16;
    localparam int COUNT_BITS = 5;
    // status word layout
    localparam int OVERCURRENT_BIT = 15;
    localparam int SUPPLY_FAULT_BIT = 14;
    localparam int UNDERLOAD_BIT = 13;
    localparam int FIELD_BASE_BIT = 1;
    localparam int FIELD_BITS = 2;
    localparam int THERMAL_WARNING_BIT = 0;
    // command word layout
    localparam int CMD_RESET_BIT = 15;
    localparam int CMD_GROUP_BIT = 14;
    // reset values and the last bit count
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [15:0] CMD_RESET = 16'h0000;
    localparam logic [4:0] COUNT_RESET = 5'h00;
    localparam logic [4:0] COUNT_LAST = 5'h10;
    // half-bridge state field codes
    localparam logic [1:0] FIELD_DISABLED = 2'h0;
    localparam logic [1:0] FIELD_OVERCURRENT = 2'h1;
    localparam logic [1:0] FIELD_UNDERLOAD = 2'h2;
    localparam logic [1:0] FIELD_ENABLED = 2'h3;
    typedef enum logic [1:0] {
        HB_DISABLED,
        HB_ENABLED,
        HB_UNDERLOAD,
        HB_OVERCURRENT
    } hb_state_type;
endpackage

// File: half_bridge_state_encoder.sv
// per half-bridge overcurrent latch and priority-encoded state field
`timescale 1ns/1ps
module half_bridge_state_encoder
    import status_word_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic enable_in,
    input wire logic overcurrent_in,
    input wire logic underload_in,
    input wire logic clear_in,
    output logic overcurrent_shutdown_latched_out,
    output logic [1:0] half_bridge_state_field_out
);
    hb_state_type state_reg;
    hb_state_type state_next;
    logic ocs_reg;
    logic ocs_next;

    // latch holds until cleared
    // a new event in the clearing cycle wins over the clear
    assign ocs_next = overcurrent_in | (ocs_reg & ~clear_in);

    always_comb begin
        if (ocs_next) begin
            state_next = HB_OVERCURRENT;
        end else if (!enable_in) begin
            state_next = HB_DISABLED;
        end else if (underload_in) begin
            state_next = HB_UNDERLOAD;
        end else begin
            state_next = HB_ENABLED;
        end
    end

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_reg <= HB_DISABLED;
            ocs_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            ocs_reg <= ocs_next;
        end
    end

    always_comb begin
        unique case (state_reg)
            HB_DISABLED: half_bridge_state_field_out = FIELD_DISABLED;
            HB_ENABLED: half_bridge_state_field_out = FIELD_ENABLED;
            HB_UNDERLOAD: half_bridge_state_field_out = FIELD_UNDERLOAD;
            HB_OVERCURRENT: half_bridge_state_field_out = FIELD_OVERCURRENT;
        endcase
    end

    assign overcurrent_shutdown_latched_out = ocs_reg;
endmodule

// File: hfsw_checker.sv
// assertions on the status word ports
`timescale 1ns/1ps
module hfsw_checker
    import status_word_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic chip_select_n_in,
    input wire logic [CHANNELS-1:0] channel_enable_in,
    input wire logic [CHANNELS-1:0] overcurrent_in,
    input wire logic [CHANNELS-1:0] underload_in,
    input wire logic thermal_shutdown_in,
    input wire logic undervoltage_in,
    input wire logic overvoltage_in,
    input wire logic serial_data_oe_n_out,
    input wire logic thermal_shutdown_latched_out,
    input wire logic [WORD_BITS-1:0] serial_status_word_out,
    input wire logic channel_group_select_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    wire logic [15:0] w = serial_status_word_out;
    wire logic g = channel_group_select_out;
    // no latched overcurrent anywhere and group 0 selected, so fields follow their pins
    wire logic quiet = !w[15] && !g;
    wire logic tsl = thermal_shutdown_latched_out;
    sequence held_idle; chip_select_n_in [*5]; endsequence
    sequence held_busy; !chip_select_n_in [*5]; endsequence
    reset_clears_a: assert property (disable iff (1'b0) !rst_n_in [*2] |-> w == 16'h0000 && !tsl)
        else $error("word not cleared in reset");
    supply_set_a: assert property ((undervoltage_in || overvoltage_in) [*7] |-> w[14])
        else $error("supply fault bit missing");
    supply_clear_a: assert property (!(undervoltage_in || overvoltage_in) [*7] |-> !w[14])
        else $error("supply fault bit stuck");
    thermal_hold_a: assert property (thermal_shutdown_in [*4] ##0 tsl |=> tsl)
        else $error("thermal latch dropped while hot");
    thermal_set_a: assert property (thermal_shutdown_in [*8] |-> tsl)
        else $error("thermal latch not set");
    hb6_off_a: assert property ((!channel_enable_in[5] && !overcurrent_in[5] && quiet) [*8]
        |-> w[12:11] == FIELD_DISABLED)
        else $error("hb6 field not disabled");
    hb5_on_a: assert property ((channel_enable_in[4] && !underload_in[4]
        && !overcurrent_in[4] && quiet) [*8] |-> w[10:9] == FIELD_ENABLED)
        else $error("hb5 field not enabled");
    hb4_under_a: assert property ((channel_enable_in[3] && underload_in[3]
        && !overcurrent_in[3] && quiet) [*8] |-> w[8:7] == FIELD_UNDERLOAD && w[13])
        else $error("hb4 underload not reported");
    hb3_over_a: assert property ((overcurrent_in[2] && !g) [*8]
        |-> w[6:5] == FIELD_OVERCURRENT && w[15])
        else $error("hb3 overcurrent not reported");
    group_zero_a: assert property (g [*8] |-> w[12:1] == 12'h000)
        else $error("other group fields not zero");
    link_idle_a: assert property (held_idle |-> serial_data_oe_n_out)
        else $error("serial output driven outside frame");
    link_drive_a: assert property (held_busy |-> !serial_data_oe_n_out)
        else $error("serial output not driven in frame");
endmodule
bind halfbridge_fault_status_word hfsw_checker u_chk (.clock_in(clock_in), .rst_n_in(rst_n_in),
    .chip_select_n_in(chip_select_n_in), .channel_enable_in(channel_enable_in),
    .overcurrent_in(overcurrent_in), .underload_in(underload_in),
    .thermal_shutdown_in(thermal_shutdown_in), .undervoltage_in(undervoltage_in),
    .overvoltage_in(overvoltage_in), .serial_data_oe_n_out(serial_data_oe_n_out),
    .thermal_shutdown_latched_out(thermal_shutdown_latched_out),
    .serial_status_word_out(serial_status_word_out),
    .channel_group_select_out(channel_group_select_out));

// File: spi_master_model.sv
// serial bus master model that runs command frames
`timescale 1ns/1ps
module spi_master_model (
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    input wire logic miso_in,
    input wire logic miso_oe_n_in
);
    // a released line has no pull, so show the inverse to catch late drive
    wire logic miso_line = miso_oe_n_in ? ~miso_in : miso_in;
    // serial clock stands low between frames
    initial begin
        sclk_out = 1'b0;
        cs_n_out = 1'b1;
        mosi_out = 1'b0;
    end
    // ********
    // one frame
    // ********
    // bit 15 of the command carries the status reset request
    task automatic frame(input logic [15:0] cmd, output logic [15:0] rsp, output logic pre);
        cs_n_out = 1'b0;
        #100;
        pre = miso_line;
        // msb first, mosi sampled on the rising edge, miso read after the falling edge
        for (int i = 15; i >= 0; i--) begin
            mosi_out = cmd[i];
            #62.5 sclk_out = 1'b1;
            #62.5 sclk_out = 1'b0;
            rsp[i] = miso_line;
        end
        #62.5 cs_n_out = 1'b1;
        mosi_out = 1'b0;
        #200;
    endtask
endmodule

// File: halfbridge_fault_status_word_tb.sv
// self-checking bench for the half-bridge status word
`timescale 1ns/1ps
module halfbridge_fault_status_word_tb;
    import status_word_pkg::*;
    logic clk, rst_n, ts, tw, uv, ov, grp, tsl, so, oe_n, sclk, cs_n, mosi, pre;
    logic [5:0] en, oc, ul, ocl;
    logic [15:0] word, rsp, exp, msk;
    int err_total, n_compared, cycles;
    halfbridge_fault_status_word u_dut (.clock_in(clk), .rst_n_in(rst_n),
        .serial_clock_in(sclk), .chip_select_n_in(cs_n), .serial_data_in(mosi),
        .channel_enable_in(en), .overcurrent_in(oc), .underload_in(ul),
        .thermal_shutdown_in(ts), .thermal_warning_in(tw), .undervoltage_in(uv),
        .overvoltage_in(ov), .serial_data_out(so), .serial_data_oe_n_out(oe_n),
        .thermal_shutdown_latched_out(tsl), .serial_status_word_out(word),
        .channel_group_select_out(grp));
    spi_master_model u_mst (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
        .miso_in(so), .miso_oe_n_in(oe_n));
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ********
    // helpers
    // ********
    function automatic logic [15:0] expect_word();
        logic [15:0] w;
        w = {ocl != 6'h00, uv | ov, |ul, 12'h000, tw};
        for (int c = 0; c < 6; c++)
            w[2*c+1 +: 2] = ocl[c] ? FIELD_OVERCURRENT : !en[c] ? FIELD_DISABLED
                : ul[c] ? FIELD_UNDERLOAD : FIELD_ENABLED;
        return w;
    endfunction
    task automatic chk(input logic [15:0] got, input logic [15:0] want);
        n_compared++;
        if (got !== want) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, want);
        end
    endtask
    task automatic settle();
        repeat (12) @(posedge clk);
        #1;
    endtask
    task automatic step(input logic [5:0] e, o, u, input logic t, w, input logic [1:0] v);
        @(posedge clk);
        en <= e;
        oc <= o;
        ul <= u;
        ts <= t;
        tw <= w;
        {uv, ov} <= v;
        ocl = ocl | o;
        settle();
        chk(word & msk, expect_word() & msk);
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // hang guard, tests need about 2550 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            err_total++;
            stop_test();
        end
    end
    // ********
    // tests
    // ********
    initial begin
        rst_n = 1'b0; en = 6'h00; oc = 6'h00; ul = 6'h00; ts = 1'b1; tw = 1'b1;
        uv = 1'b1; ov = 1'b0; ocl = 6'h00; msk = 16'hFFFF;
        err_total = 0; n_compared = 0; cycles = 0;
        repeat (2) @(posedge clk);
        #1;
        chk({tsl, word[14:0]}, 16'h0000);
        @(posedge clk) rst_n <= 1'b1;
        step(6'h00, 6'h00, 6'h00, 1'b0, 1'b0, 2'b10);
        step(6'h00, 6'h00, 6'h00, 1'b0, 1'b0, 2'b01);
        step(6'h00, 6'h00, 6'h00, 1'b0, 1'b0, 2'b00);
        step(6'h3F, 6'h00, 6'h00, 1'b0, 1'b1, 2'b00);
        step(6'h1F, 6'h00, 6'h1C, 1'b0, 1'b1, 2'b00);
        step(6'h1F, 6'h0C, 6'h18, 1'b0, 1'b1, 2'b00);
        step(6'h1F, 6'h04, 6'h10, 1'b1, 1'b1, 2'b00);
        msk = 16'hDFFF;
        // overcurrent latched channel must not fall back to underload
        step(6'h1F, 6'h00, 6'h1C, 1'b1, 1'b1, 2'b00);
        msk = 16'hFFFF;
        step(6'h1F, 6'h00, 6'h10, 1'b1, 1'b1, 2'b00);
        chk({15'h0000, tsl}, 16'h0001);
        exp = expect_word();
        fork
            u_mst.frame(16'h0000, rsp, pre);
            begin
                repeat (60) @(posedge clk);
                tw <= 1'b0;
            end
        join
        chk(rsp, exp);
        chk({15'h0000, pre}, 16'h0001);
        step(6'h1F, 6'h00, 6'h10, 1'b0, 1'b0, 2'b00);
        chk({15'h0000, tsl}, 16'h0001);
        u_mst.frame(16'h8000, rsp, pre);
        ocl = 6'h00;
        settle();
        chk({tsl, word[14:0]}, expect_word());
        u_mst.frame(16'h4000, rsp, pre);
        settle();
        chk(word, expect_word() & 16'hE001);
        chk({15'h0000, grp}, 16'h0001);
        u_mst.frame(16'h0000, rsp, pre);
        settle();
        chk({grp, word[14:0]}, expect_word());
        @(posedge clk) rst_n <= 1'b0;
        settle();
        chk(word, 16'h0000);
        stop_test();
    end
endmodule
